/* rtl/etmf_link_edge.sv */
// etmf_link_edge.sv: finds rising edges of the tx link clock in the mclk domain
// assumes link clock well below mclk/4 (25 MHz at most against 100 MHz)
`default_nettype none

module etmf_link_edge (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic link_clk_i,
  output logic      rise_o
);

  typedef struct packed {
    logic [2:0] sh;
    logic       level;
    logic       rise;
  } etmf_edge_t;

  etmf_edge_t st_r;
  etmf_edge_t st_nxt;

  // ----------------------------------------
  // three stages, level moves only when stages two and three agree
  // ----------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sh   = {st_r.sh[1:0], link_clk_i};
    st_nxt.rise = 1'b0;
    if (st_r.sh[1] == st_r.sh[2] && st_r.sh[2] != st_r.level) begin
      st_nxt.level = st_r.sh[2];
      st_nxt.rise  = st_r.sh[2];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise_o = st_r.rise;

  rise_once_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    st_r.rise |=> !st_r.rise)
    else $error("link edge pulse longer than one cycle");

endmodule : etmf_link_edge

`default_nettype wire

/* rtl/etmf_pkg.sv */
// etmf_pkg.sv: shared constants for the missed-frame counter and tx start threshold block
// assumes a 32-bit Avalon-MM slave port, byte addresses, one register per aligned word
//
// Notes on behaviour
// - missed-frame count is 16 bits wide, bits 31..16 read as zero
// - on receive FIFO overflow, discarded frame count is added to the count
// - count saturates at all ones, further discards leave it unchanged
// - reading the count returns it and then clears it to zero
// - writes to the count register are ignored
// - threshold in bytes is four times the threshold field
// - first transmission starts when level exceeds threshold, FIFO full, or frame written
// - threshold zero means store-and-forward, which is the reset value
// - threshold field is bits 10..0, meaningful codes up to the 512-byte one
// - threshold bits 31..11 read zero, software writes only zero there
// - at 10 Mbps, codes one to twelve may fail to transmit
// - at 100 Mbps every threshold code works
// - tx FIFO depth is one bit, 256 or 512 bytes, frozen once traffic started
`default_nettype none

package etmf_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W       = 5;
  localparam logic [4:0]  OFF_MISSED   = 5'h00;
  localparam logic [4:0]  OFF_THRESH   = 5'h04;
  localparam logic [4:0]  OFF_DEPTH    = 5'h08;
  localparam logic [4:0]  OFF_CTRL     = 5'h0C;
  localparam logic [4:0]  OFF_STATUS   = 5'h10;
  localparam logic [4:0]  OFF_IRQ_STS  = 5'h14;
  localparam logic [4:0]  OFF_IRQ_MASK = 5'h18;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned MFC_W        = 16;
  localparam int unsigned THR_W        = 11;
  localparam int unsigned DEPTH_BIT    = 8;
  localparam int unsigned CTRL_TXEN    = 0;
  localparam int unsigned CTRL_SPEED   = 1;
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_DISCARD  = 0;
  localparam int unsigned IRQ_TXSTART  = 1;
  localparam int unsigned IRQ_SATURATE = 2;
  localparam int unsigned IRQ_SLOWTHR  = 3;
  localparam logic [15:0] MFC_RST      = 16'h0000;
  localparam logic [15:0] MFC_MAX      = 16'hFFFF;
  localparam logic [10:0] THR_RST      = 11'h000;
  localparam logic [10:0] THR_MAX      = 11'h080;
  localparam logic [10:0] THR_SLOW_LO  = 11'h001;
  localparam logic [10:0] THR_SLOW_HI  = 11'h00C;
  localparam logic [12:0] DEPTH_SMALL  = 13'h0100;
  localparam logic [12:0] DEPTH_LARGE  = 13'h0200;

  typedef enum logic [1:0] {
    ETMF_TX_IDLE,
    ETMF_TX_WAIT,
    ETMF_TX_SEND
  } etmf_tx_state_t;

endpackage : etmf_pkg

`default_nettype wire

/* rtl/etmf_top.sv */
// etmf_top.sv: receive missed-frame counter and transmit FIFO start threshold
// assumes the rx FIFO reports overflow with a frame count, the tx FIFO reports its level,
// and the tx engine pulses tx_frame_done_i in the mclk domain at the end of each frame
`default_nettype none

module etmf_top
  import etmf_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              rx_overflow_i,
  input  wire logic [7:0]        rx_discard_frames_i,
  input  wire logic              rx_active_i,
  input  wire logic [9:0]        tx_fifo_level_i,
  input  wire logic              tx_frame_written_i,
  input  wire logic              tx_frame_done_i,
  input  wire logic              tx_link_clk_i,
  output logic                   tx_en_o,
  output logic                   tx_depth_512_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic [MFC_W-1:0]  missed_count_field;
    logic [THR_W-1:0]  thr;
    logic              depth_sel;
    logic              started;
    logic              tx_enable;
    logic              speed100;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_mask;
    logic              tx_en;
    etmf_tx_state_t    txs;
  } etmf_state_t;

  etmf_state_t st_r;
  etmf_state_t st_nxt;

  logic        link_rise;
  logic [31:0] be_mask;
  logic        rd_cap;
  logic        wr_do;
  logic [12:0] level_b;
  logic [12:0] thr_b;
  logic [12:0] depth_b;
  logic        fifo_full;
  logic        over_thr;
  logic        start_cond;
  logic        slow_hazard;

  // ----------------------------------------
  // link clock edge finder
  // ----------------------------------------
  etmf_link_edge u_link_edge (
    .mclk_i     (mclk_i),
    .reset_n_i  (reset_n_i),
    .link_clk_i (tx_link_clk_i),
    .rise_o     (link_rise)
  );

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // reads are captured on the first cycle so the clear and the snapshot share one edge;
  // writes land on the edge where the master sees waitrequest low
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_r.ack;
  assign rd_cap            = avs_read_i & ~st_r.ack;
  assign wr_do             = avs_write_i & st_r.ack;

  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign be_mask[8*g +: 8] = {8{avs_byteenable_i[g]}};
  end

  // ----------------------------------------
  // start decision
  // ----------------------------------------
  assign level_b     = {3'h0, tx_fifo_level_i};
  assign thr_b       = {st_r.thr, 2'b00};
  assign depth_b     = st_r.depth_sel ? DEPTH_LARGE : DEPTH_SMALL;
  assign fifo_full   = level_b >= depth_b;
  // code zero disables the byte compare: store-and-forward
  assign over_thr    = (st_r.thr != THR_RST) && (level_b > thr_b);
  assign start_cond  = over_thr | fifo_full | tx_frame_written_i;
  // slow link with a short threshold can starve the line; flagged, not blocked
  assign slow_hazard = !st_r.speed100 && (st_r.thr >= THR_SLOW_LO)
                       && (st_r.thr <= THR_SLOW_HI);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [16:0] sum;
    logic [15:0] base;
    logic [IRQ_W-1:0] set_v;
    sum    = 17'h00000;
    base   = 16'h0000;
    set_v  = {IRQ_W{1'b0}};
    st_nxt = st_r;
    st_nxt.ack = (avs_read_i | avs_write_i) & ~st_r.ack;

    // missed-frame counter
    base = rd_cap && (avs_address_i == OFF_MISSED) ? MFC_RST : st_r.missed_count_field;
    sum  = {1'b0, base} + {9'h000, rx_discard_frames_i};
    if (rx_overflow_i) begin
      st_nxt.missed_count_field = sum[16] ? MFC_MAX : sum[15:0];
      set_v[IRQ_DISCARD] = 1'b1;
      if (sum[16] || sum[15:0] == MFC_MAX) begin
        set_v[IRQ_SATURATE] = 1'b1;
      end
    end else begin
      st_nxt.missed_count_field = base;
    end
    // event sets kept apart so a clearing write in the same cycle cannot eat them
    st_nxt.irq_sts = st_r.irq_sts | set_v;

    // read snapshot, unmapped and reserved bits read zero
    if (rd_cap) begin
      unique case (avs_address_i)
        OFF_MISSED:   st_nxt.rdata = {16'h0000, st_r.missed_count_field};
        OFF_THRESH:   st_nxt.rdata = {21'h000000, st_r.thr};
        OFF_DEPTH:    st_nxt.rdata = {23'h000000, st_r.depth_sel, 8'h00};
        OFF_CTRL:     st_nxt.rdata = {30'h00000000, st_r.speed100, st_r.tx_enable};
        OFF_STATUS:   st_nxt.rdata = {29'h00000000, slow_hazard, st_r.started, st_r.tx_en};
        OFF_IRQ_STS:  st_nxt.rdata = {28'h0000000, st_r.irq_sts};
        OFF_IRQ_MASK: st_nxt.rdata = {28'h0000000, st_r.irq_mask};
        default:      st_nxt.rdata = 32'h00000000;
      endcase
    end

    // writes; the count register has no write path
    if (wr_do) begin
      unique case (avs_address_i)
        OFF_THRESH: begin
          st_nxt.thr = (st_r.thr & ~be_mask[10:0]) | (avs_writedata_i[10:0] & be_mask[10:0]);
        end
        OFF_DEPTH: begin
          if (!st_r.started && be_mask[DEPTH_BIT]) begin
            st_nxt.depth_sel = avs_writedata_i[DEPTH_BIT];
          end
        end
        OFF_CTRL: begin
          if (be_mask[0]) begin
            st_nxt.tx_enable = avs_writedata_i[CTRL_TXEN];
            st_nxt.speed100  = avs_writedata_i[CTRL_SPEED];
          end
        end
        OFF_IRQ_STS: begin
          // hardware sets win over the clear
          st_nxt.irq_sts = st_r.irq_sts
                           & ~(avs_writedata_i[IRQ_W-1:0] & be_mask[IRQ_W-1:0])
                           | set_v;
        end
        OFF_IRQ_MASK: begin
          st_nxt.irq_mask = (st_r.irq_mask & ~be_mask[IRQ_W-1:0])
                            | (avs_writedata_i[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
        end
        default: begin
        end
      endcase
    end

    if (rx_active_i) begin
      st_nxt.started = 1'b1;
    end

    // transmit start, aligned to a link clock rising edge
    unique case (st_r.txs)
      ETMF_TX_IDLE: begin
        if (st_r.tx_enable && start_cond) begin
          st_nxt.txs = ETMF_TX_WAIT;
        end
      end
      ETMF_TX_WAIT: begin
        if (!st_r.tx_enable) begin
          st_nxt.txs = ETMF_TX_IDLE;
        end else if (link_rise) begin
          st_nxt.txs     = ETMF_TX_SEND;
          st_nxt.tx_en   = 1'b1;
          st_nxt.started = 1'b1;
          st_nxt.irq_sts[IRQ_TXSTART] = 1'b1;
          if (slow_hazard) begin
            st_nxt.irq_sts[IRQ_SLOWTHR] = 1'b1;
          end
        end
      end
      ETMF_TX_SEND: begin
        if (tx_frame_done_i) begin
          st_nxt.txs   = ETMF_TX_IDLE;
          st_nxt.tx_en = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_r           <= '0;
      st_r.missed_count_field       <= MFC_RST;
      st_r.thr       <= THR_RST;
      st_r.txs       <= ETMF_TX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o = st_r.rdata;
  assign tx_en_o        = st_r.tx_en;
  assign tx_depth_512_o = st_r.depth_sel;
  assign irq_o          = |(st_r.irq_sts & st_r.irq_mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  logic             mfc_rd;
  logic             irq_sts_txstart;
  logic [THR_W-1:0] wd_thr;
  assign mfc_rd          = rd_cap && (avs_address_i == OFF_MISSED);
  assign irq_sts_txstart = st_r.irq_sts[IRQ_TXSTART];
  assign wd_thr          = avs_writedata_i[THR_W-1:0];

  sequence s_armed;
    (st_r.txs == ETMF_TX_IDLE) && st_r.tx_enable && start_cond;
  endsequence

  sequence s_edge_seen;
    (st_r.txs == ETMF_TX_WAIT) && st_r.tx_enable && link_rise;
  endsequence

  mfc_upper_zero_a: assert property (
    mfc_rd |=> st_r.rdata[31:16] == 16'h0000 && st_r.rdata[15:0] == $past(st_r.missed_count_field))
    else $error("count read not 16-bit snapshot");

  mfc_add_a: assert property (
    !mfc_rd && rx_overflow_i && st_r.missed_count_field < 16'hFF00
    |=> st_r.missed_count_field == 16'($past(st_r.missed_count_field) + {8'h00, $past(rx_discard_frames_i)}))
    else $error("discarded frames not added");

  mfc_saturate_a: assert property (
    !mfc_rd && st_r.missed_count_field == MFC_MAX |=> st_r.missed_count_field == MFC_MAX)
    else $error("count left saturation");

  mfc_clear_a: assert property (
    mfc_rd && !rx_overflow_i |=> st_r.missed_count_field == MFC_RST)
    else $error("count not cleared by read");

  mfc_write_a: assert property (
    avs_write_i && avs_address_i == OFF_MISSED && !rx_overflow_i |=> $stable(st_r.missed_count_field))
    else $error("write changed count");

  mfc_race_a: assert property (
    mfc_rd && rx_overflow_i |=> st_r.missed_count_field == {8'h00, $past(rx_discard_frames_i)})
    else $error("discard lost on clearing read");

  thr_upper_zero_a: assert property (
    rd_cap && avs_address_i == OFF_THRESH |=> st_r.rdata[31:11] == 21'h000000)
    else $error("threshold upper bits not zero");

  tx_arm_a: assert property (
    s_armed |=> st_r.txs == ETMF_TX_WAIT)
    else $error("start condition did not arm transmit");

  tx_start_a: assert property (
    s_edge_seen |=> tx_en_o ##0 irq_sts_txstart)
    else $error("transmission did not start on link edge");

  tx_hold_a: assert property (
    st_r.txs == ETMF_TX_SEND && !tx_frame_done_i |=> tx_en_o)
    else $error("transmit enable dropped before frame end");

  tx_end_a: assert property (
    st_r.txs == ETMF_TX_SEND && tx_frame_done_i |=> !tx_en_o)
    else $error("transmit enable held after frame end");

  tx_abort_a: assert property (
    st_r.txs == ETMF_TX_WAIT && !st_r.tx_enable |=> st_r.txs == ETMF_TX_IDLE && !tx_en_o)
    else $error("disabled transmit did not return to idle");

  slow_flag_a: assert property (
    s_edge_seen ##0 slow_hazard |=> st_r.irq_sts[IRQ_SLOWTHR])
    else $error("slow threshold start not flagged");

  fast_ok_a: assert property (
    st_r.speed100 |-> !slow_hazard)
    else $error("hazard flagged at fast line rate");

  saf_hold_a: assert property (
    st_r.txs == ETMF_TX_IDLE && st_r.thr == THR_RST && !fifo_full && !tx_frame_written_i
    |=> st_r.txs == ETMF_TX_IDLE)
    else $error("store-and-forward started early");

  depth_lock_a: assert property (
    st_r.started |=> $stable(st_r.depth_sel))
    else $error("depth changed after traffic started");

  irq_level_a: assert property (
    s_edge_seen ##0 st_r.irq_mask[IRQ_TXSTART] ##1 st_r.irq_mask[IRQ_TXSTART] |-> irq_o)
    else $error("unmasked status without interrupt");

  irq_set_wins_a: assert property (
    rx_overflow_i |=> st_r.irq_sts[IRQ_DISCARD])
    else $error("discard event lost against clear");

  mfc_sat_flag_a: assert property (
    rx_overflow_i && !mfc_rd && st_r.missed_count_field == MFC_MAX |=> st_r.irq_sts[IRQ_SATURATE])
    else $error("saturation not flagged");

  mfc_no_wrap_a: assert property (
    !mfc_rd |=> st_r.missed_count_field >= $past(st_r.missed_count_field))
    else $error("count decreased without a read");

  ack_pulse_a: assert property (
    st_r.ack |=> !st_r.ack)
    else $error("bus acknowledge longer than one cycle");

  wait_one_a: assert property (
    (avs_read_i || avs_write_i) && !st_r.ack |=> st_r.ack)
    else $error("bus request not answered after one wait");

  rd_hold_a: assert property (
    !rd_cap |=> $stable(st_r.rdata))
    else $error("read data changed without a read");

  thr_write_a: assert property (
    wr_do && avs_address_i == OFF_THRESH && avs_byteenable_i[0] && avs_byteenable_i[1]
    |=> st_r.thr == $past(wd_thr))
    else $error("threshold write not stored");

endmodule : etmf_top

`default_nettype wire

/* tb/etmf_phy_model.sv */
// phy stand-in: link clock and end of frame
// assumes tx_en_i is the block's transmit enable
`default_nettype none

module etmf_phy_model (
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic tx_en_i,
  output logic      link_clk_o,
  output logic      done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] beat_r;
  // clock stands low while run_i is low; offset keeps it off mclk edges
  initial begin
    link_clk_o = 1'b0;
    #3;
    forever begin
      #40;
      link_clk_o = run_i ? ~link_clk_o : 1'b0;
    end
  end
  // a frame lasts 64 cycles, then one done pulse
  initial done_o = 1'b0;
  initial beat_r = 6'h00;
  always @(posedge mclk_i) begin
    beat_r <= tx_en_i ? beat_r + 6'h01 : 6'h00;
    done_o <= tx_en_i && beat_r == 6'h3F;
  end
endmodule : etmf_phy_model

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for etmf_top
// assumes etmf_pkg, the design and the phy model are compiled first
`default_nettype none

module testbench;
  import etmf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_i = 0, reset_n_i = 0, rd = 0, wr = 0, ov = 0;
  logic              act = 0, fw = 0, run = 0, wt, ten, dep, irq, lclk, done;
  logic [4:0]        adr = '0;
  logic [31:0]       wd = '0, rdata, q;
  logic [7:0]        dn = '0;
  logic [9:0]        lvl = '0;
  int                n_fail = 0, checks = 0, mc = 0, depth_bytes = 256;
  int unsigned       seed = 63375;

  etmf_top etmf_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .rx_overflow_i(ov),
    .rx_discard_frames_i(dn), .rx_active_i(act), .tx_fifo_level_i(lvl),
    .tx_frame_written_i(fw), .tx_frame_done_i(done), .tx_link_clk_i(lclk),
    .tx_en_o(ten), .tx_depth_512_o(dep), .irq_o(irq));
  etmf_phy_model etmf_phy_model_inst (.mclk_i(mclk_i), .run_i(run), .tx_en_i(ten),
    .link_clk_o(lclk), .done_o(done));

  always #5 mclk_i = ~mclk_i;

  // ----
  // helpers
  // ----
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one avalon transfer; waits for waitrequest low, bounded
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      print_verdict();
    end
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdchk

  task automatic ovf(input int n);
    @(posedge mclk_i);
    ov <= 1'b1;
    dn <= 8'(n);
    @(posedge mclk_i);
    ov <= 1'b0;
    mc = (mc + n > 65535) ? 65535 : mc + n;
  endtask : ovf

  // threshold is written only while transmission is halted
  task automatic start(input int t, input int l, input logic f, input logic spd);
    logic e;
    int   n;
    e = (t != 0 && l > 4 * t) || l >= depth_bytes || f;
    bus(1'b1, OFF_THRESH, 32'(t));
    lvl <= 10'(l);
    fw <= f;
    run <= 1'b1;
    bus(1'b1, OFF_CTRL, {30'h0, spd, 1'b1});
    n = 0;
    while (ten !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    chk(32'(ten), 32'(e));
    lvl <= 10'h000;
    fw <= 1'b0;
    n = 0;
    while (ten !== 1'b0 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    chk(32'(ten), 32'h0);
    bus(1'b1, OFF_CTRL, 32'h0);
    run <= 1'b0;
  endtask : start

  // ----
  // scenarios
  // ----
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rdchk(OFF_MISSED, 32'h0);
    rdchk(OFF_THRESH, 32'h0);
    rdchk(OFF_DEPTH, 32'h0);
    rdchk(5'h1C, 32'h0);
    bus(1'b1, OFF_IRQ_MASK, 32'h2);
    rdchk(OFF_IRQ_MASK, 32'h2);
    $display("test reset done");
    for (int i = 0; i < 5; i++) ovf(int'(rnd() % 256));
    chk(32'(irq), 32'h0);
    bus(1'b1, OFF_MISSED, 32'hFFFF);
    rdchk(OFF_MISSED, mc);
    mc = 0;
    rdchk(OFF_MISSED, 32'h0);
    for (int i = 0; i < 260; i++) ovf(255);
    rdchk(OFF_MISSED, mc);
    mc = 0;
    ovf(5);
    // discard lands on the edge that applies the clearing read
    fork
      bus(1'b0, OFF_MISSED, 32'h0);
      begin
        @(posedge mclk_i);
        ov <= 1'b1;
        dn <= 8'h03;
        @(posedge mclk_i);
        ov <= 1'b0;
      end
    join
    chk(q, mc);
    rdchk(OFF_MISSED, 32'h3);
    rdchk(OFF_IRQ_STS, 32'h5);
    $display("test missed count done");
    bus(1'b1, OFF_THRESH, 32'hFFFFFFFF);
    rdchk(OFF_THRESH, 32'h7FF);
    start(0, 200, 1'b0, 1'b0);
    start(0, 10, 1'b1, 1'b0);
    start(13, 52, 1'b0, 1'b0);
    start(13, 53, 1'b0, 1'b0);
    chk(32'(irq), 32'h1);
    start(0, 256, 1'b0, 1'b0);
    // codes below 256 bytes only, as depth stays at 256
    for (int i = 0; i < 6; i++) start(int'(rnd() % 63 + 1), int'(rnd() % 256), 1'b0, 1'b1);
    $display("test tx start done");
    act <= 1'b1;
    bus(1'b1, OFF_DEPTH, 32'h100);
    rdchk(OFF_DEPTH, 32'h0);
    chk(32'(dep), 32'h0);
    rdchk(OFF_IRQ_STS, 32'h7);
    bus(1'b1, OFF_IRQ_STS, 32'hF);
    rdchk(OFF_IRQ_STS, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test lock and irq done");
    // second reset so the depth can be chosen before any traffic
    act <= 1'b0;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_CTRL, 32'h0);
    bus(1'b1, OFF_DEPTH, 32'h100);
    rdchk(OFF_DEPTH, 32'h100);
    chk(32'(dep), 32'h1);
    depth_bytes = 512;
    start(64, 300, 1'b0, 1'b1);
    start(0, 300, 1'b0, 1'b1);
    start(0, 512, 1'b0, 1'b1);
    $display("test depth 512 done");
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
